// ### verilog/plc_access_pkg.sv
package plc_access_pkg;

    // ***********************************************
    // widths
    // ***********************************************
    localparam int SYM_W = 16;
    localparam int CNT_W = 8;
    localparam int EXP_W = 4;
    localparam int TMR_W = 32;
    localparam int RND_W = 16;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESPONSE_SLACK_NS = 1000;
    localparam int RESPONSE_SLACK_CYC_RAW = (RESPONSE_SLACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESPONSE_SLACK_CYC = (RESPONSE_SLACK_CYC_RAW < 1) ? 1 : RESPONSE_SLACK_CYC_RAW;

    // ***********************************************
    // reset values
    // ***********************************************
    localparam logic [RND_W-1:0] LFSR_SEED = 16'hace1;
    localparam logic [RND_W-1:0] LFSR_TAPS = 16'hb400;
    localparam logic [TMR_W-1:0] TIMER_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [EXP_W-1:0] EXP_RESET = 4'h0;

    // ***********************************************
    // access sequencer states
    // ***********************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BACKOFF,
        ST_ASSESS,
        ST_TRANSMIT,
        ST_WAIT_RESP
    } access_state_e;

endpackage : plc_access_pkg

// ### verilog/rand_if.sv
interface rand_if;
    logic advance;
    logic [plc_access_pkg::RND_W-1:0] value;

    modport gen (input advance, output value);
    modport user (output advance, input value);
endinterface : rand_if

// ### verilog/backoff_lfsr.sv
// ***********************************************
// pseudo random source for backoff draws
// ***********************************************
module backoff_lfsr (
    input wire logic clk_i,
    input wire logic rst_n_i,
    rand_if.gen rnd
);

    logic [plc_access_pkg::RND_W-1:0] lfsr_q;

    // galois shift, steps only while the user asks for it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lfsr_q <= plc_access_pkg::LFSR_SEED;
        end else if (rnd.advance && lfsr_q[0]) begin
            lfsr_q <= (lfsr_q >> 1) ^ plc_access_pkg::LFSR_TAPS;
        end else if (rnd.advance) begin
            lfsr_q <= lfsr_q >> 1;
        end
    end

    assign rnd.value = lfsr_q;

endmodule : backoff_lfsr

// ### verilog/plc_mac_channel_access.sv
// Overview of operation
// - pending frame waits a random backoff before sampling the medium
// - idle medium after backoff starts transmission of the pending frame
// - busy medium after backoff draws and waits a fresh random backoff
// - virtual busy timer loaded from received length or collision, marks busy
// - virtual busy timer load differs for long data and short ack frames
// - virtual busy timer also loaded on collision and after power up
// - medium counts busy while the station itself transmits
// - unexpected non ack non nack reply during response wait flags collision
// - missing reply when one is expected flags collision
// - response gap timed from end of own transmission
// - contention gap timed from end of transmission without expected reply
// - extended gap runs at power up and after undecodable frames
// - correctly decoded frame cancels a running extended gap at once
// - extended gap length is symbol time times summed counts plus ack time
// - backoff is whole periods uniform from zero to two power exponent minus one
// - busy assessment bumps attempt count and exponent, exponent clamped
// - attempt count above limit abandons frame with access failure
module plc_mac_channel_access (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic TX_REQ_I,
    input wire logic TX_ACK_REQ_I,
    input wire logic TX_ACTIVE_I,
    input wire logic PHY_CARRIER_DETECT_I,
    input wire logic RX_START_I,
    input wire logic RX_IS_DATA_I,
    input wire logic [plc_access_pkg::SYM_W-1:0] RX_LENGTH_I,
    input wire logic RX_END_I,
    input wire logic RX_OK_I,
    input wire logic RX_IS_ACK_I,
    input wire logic RX_IS_NACK_I,
    input wire logic [plc_access_pkg::SYM_W-1:0] SYMBOL_DURATION_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] HEADER_SYMBOL_COUNT_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] MAX_FRAME_LENGTH_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] CONTENTION_GAP_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] RESPONSE_GAP_I,
    input wire logic [plc_access_pkg::SYM_W-1:0] ACKNOWLEDGE_DURATION_I,
    input wire logic [plc_access_pkg::SYM_W-1:0] BACKOFF_PERIOD_I,
    input wire logic [plc_access_pkg::EXP_W-1:0] MIN_BACKOFF_EXPONENT_I,
    input wire logic [plc_access_pkg::EXP_W-1:0] BACKOFF_EXPONENT_CEILING_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] BACKOFF_ATTEMPT_LIMIT_I,
    output logic TX_START_O,
    output logic TX_DONE_O,
    output logic COLLISION_O,
    output logic ACCESS_FAIL_O,
    output logic MEDIUM_BUSY_O,
    output logic EXTENDED_GAP_O,
    output logic [plc_access_pkg::EXP_W-1:0] BACKOFF_EXPONENT_O,
    output logic [plc_access_pkg::CNT_W-1:0] BACKOFF_ATTEMPT_COUNT_O
);

    localparam int TW = plc_access_pkg::TMR_W;

    plc_access_pkg::access_state_e state_q;
    logic [TW-1:0] extended_gap_length_q;
    logic [TW-1:0] virtual_busy_timer_q;
    logic [TW-1:0] contention_gap_q;
    logic [TW-1:0] response_gap_q;
    logic [TW-1:0] extended_gap_q;
    logic [plc_access_pkg::EXP_W-1:0] backoff_exponent_q;
    logic [plc_access_pkg::CNT_W-1:0] backoff_attempt_count_q;
    logic [plc_access_pkg::RND_W-1:0] slot_cnt_q;
    logic [plc_access_pkg::SYM_W-1:0] period_cnt_q;
    logic powerup_q;
    logic tx_active_q;
    logic ack_wanted_q;
    logic resp_started_q;
    logic tx_end;
    logic collision;
    logic medium_busy;
    logic [plc_access_pkg::EXP_W-1:0] exp_next;
    logic [plc_access_pkg::CNT_W-1:0] attempt_next;
    logic [plc_access_pkg::RND_W-1:0] slot_draw;
    logic [TW-1:0] contention_gap_cycles;
    logic [TW-1:0] response_gap_cycles;
    logic [TW-1:0] ack_cycles;
    logic [TW-1:0] rx_load;
    logic [TW-1:0] sum_symbols;

    rand_if rnd ();

    // ***********************************************
    // random source
    // ***********************************************
    backoff_lfsr u_lfsr (
        .clk_i(CLK_I),
        .rst_n_i(NRST_I),
        .rnd(rnd.gen)
    );

    assign rnd.advance = (state_q == plc_access_pkg::ST_IDLE)
        || (state_q == plc_access_pkg::ST_ASSESS);

    // ***********************************************
    // durations in clock cycles
    // ***********************************************
    assign contention_gap_cycles = TW'(SYMBOL_DURATION_I) * TW'(CONTENTION_GAP_I);
    assign response_gap_cycles = TW'(SYMBOL_DURATION_I) * TW'(RESPONSE_GAP_I);
    assign ack_cycles = TW'(ACKNOWLEDGE_DURATION_I);
    assign sum_symbols = TW'(HEADER_SYMBOL_COUNT_I) + TW'(MAX_FRAME_LENGTH_I)
        + TW'(CONTENTION_GAP_I) + TW'(RESPONSE_GAP_I);

    // data frame is followed by its ack, short frame by contention
    always_comb begin
        rx_load = TW'(SYMBOL_DURATION_I) * TW'(RX_LENGTH_I);
        if (RX_IS_DATA_I) begin
            rx_load = rx_load + response_gap_cycles + ack_cycles;
        end else begin
            rx_load = rx_load + contention_gap_cycles;
        end
    end

    // extended gap length, kept live in reset so power up loads a real value
    always_ff @(posedge CLK_I) begin
        extended_gap_length_q <= TW'(SYMBOL_DURATION_I) * sum_symbols + ack_cycles;
    end

    // ***********************************************
    // medium state
    // ***********************************************
    assign tx_end = tx_active_q && !TX_ACTIVE_I;

    // busy unless every source of occupancy is quiet
    assign medium_busy = PHY_CARRIER_DETECT_I
        || (virtual_busy_timer_q != '0)
        || (contention_gap_q != '0)
        || (response_gap_q != '0)
        || (extended_gap_q != '0)
        || TX_ACTIVE_I || (state_q == plc_access_pkg::ST_TRANSMIT)
        || powerup_q;

    // reply check while a response is awaited
    always_comb begin
        collision = 1'b0;
        if (state_q == plc_access_pkg::ST_WAIT_RESP) begin
            if (RX_END_I && resp_started_q && !(RX_OK_I && (RX_IS_ACK_I || RX_IS_NACK_I))) begin
                collision = 1'b1;
            end else if (!resp_started_q && !RX_START_I && response_gap_q == TW'(1)) begin
                collision = 1'b1;
            end
        end
    end

    // transmit activity history and power up marker
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tx_active_q <= 1'b0;
            powerup_q <= 1'b1;
        end else begin
            tx_active_q <= TX_ACTIVE_I;
            powerup_q <= 1'b0;
        end
    end

    // virtual busy timer
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            virtual_busy_timer_q <= plc_access_pkg::TIMER_RESET;
        end else if (powerup_q) begin
            virtual_busy_timer_q <= extended_gap_length_q;
        end else if (collision) begin
            virtual_busy_timer_q <= contention_gap_cycles + ack_cycles;
        end else if (RX_START_I) begin
            virtual_busy_timer_q <= rx_load;
        end else if (virtual_busy_timer_q != '0) begin
            virtual_busy_timer_q <= virtual_busy_timer_q - TW'(1);
        end
    end

    // extended gap: armed at power up and on bad frames
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            extended_gap_q <= plc_access_pkg::TIMER_RESET;
        end else if (powerup_q) begin
            extended_gap_q <= extended_gap_length_q;
        end else if (RX_END_I && !RX_OK_I) begin
            extended_gap_q <= extended_gap_length_q;
        end else if (RX_END_I && RX_OK_I) begin
            extended_gap_q <= plc_access_pkg::TIMER_RESET;
        end else if (extended_gap_q != '0) begin
            extended_gap_q <= extended_gap_q - TW'(1);
        end
    end

    // contention gap from end of a transmission with no reply due
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            contention_gap_q <= plc_access_pkg::TIMER_RESET;
        end else if (tx_end && !ack_wanted_q) begin
            contention_gap_q <= contention_gap_cycles;
        end else if (contention_gap_q != '0) begin
            contention_gap_q <= contention_gap_q - TW'(1);
        end
    end

    // response window from end of transmission to start of reply
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            response_gap_q <= plc_access_pkg::TIMER_RESET;
        end else if (tx_end && ack_wanted_q) begin
            response_gap_q <= response_gap_cycles + ack_cycles
                + TW'(plc_access_pkg::RESPONSE_SLACK_CYC);
        end else if (RX_START_I || collision) begin
            response_gap_q <= plc_access_pkg::TIMER_RESET;
        end else if (response_gap_q != '0) begin
            response_gap_q <= response_gap_q - TW'(1);
        end
    end

    // ***********************************************
    // backoff arithmetic
    // ***********************************************
    assign attempt_next = backoff_attempt_count_q + plc_access_pkg::CNT_W'(1);
    assign exp_next = (backoff_exponent_q >= BACKOFF_EXPONENT_CEILING_I)
        ? BACKOFF_EXPONENT_CEILING_I : backoff_exponent_q + plc_access_pkg::EXP_W'(1);

    // uniform draw masked to two power exponent minus one
    always_comb begin
        slot_draw = rnd.value
            & plc_access_pkg::RND_W'((plc_access_pkg::RND_W'(1) << exp_next) - 1'b1);
        if (state_q == plc_access_pkg::ST_IDLE) begin
            slot_draw = rnd.value & plc_access_pkg::RND_W'(
                (plc_access_pkg::RND_W'(1) << MIN_BACKOFF_EXPONENT_I) - 1'b1);
        end
    end

    // ***********************************************
    // access sequencer
    // ***********************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_q <= plc_access_pkg::ST_IDLE;
            backoff_exponent_q <= plc_access_pkg::EXP_RESET;
            backoff_attempt_count_q <= plc_access_pkg::COUNT_RESET;
            slot_cnt_q <= '0;
            period_cnt_q <= '0;
            ack_wanted_q <= 1'b0;
            resp_started_q <= 1'b0;
        end else begin
            case (state_q)
                plc_access_pkg::ST_IDLE: begin
                    if (TX_REQ_I) begin
                        backoff_exponent_q <= MIN_BACKOFF_EXPONENT_I;
                        backoff_attempt_count_q <= plc_access_pkg::COUNT_RESET;
                        ack_wanted_q <= TX_ACK_REQ_I;
                        slot_cnt_q <= slot_draw;
                        period_cnt_q <= BACKOFF_PERIOD_I;
                        state_q <= plc_access_pkg::ST_BACKOFF;
                    end
                end
                plc_access_pkg::ST_BACKOFF: begin
                    if (slot_cnt_q == '0) begin
                        state_q <= plc_access_pkg::ST_ASSESS;
                    end else if (period_cnt_q <= plc_access_pkg::SYM_W'(1)) begin
                        period_cnt_q <= BACKOFF_PERIOD_I;
                        slot_cnt_q <= slot_cnt_q - plc_access_pkg::RND_W'(1);
                    end else begin
                        period_cnt_q <= period_cnt_q - plc_access_pkg::SYM_W'(1);
                    end
                end
                plc_access_pkg::ST_ASSESS: begin
                    if (!medium_busy) begin
                        state_q <= plc_access_pkg::ST_TRANSMIT;
                    end else begin
                        backoff_attempt_count_q <= attempt_next;
                        backoff_exponent_q <= exp_next;
                        if (attempt_next > BACKOFF_ATTEMPT_LIMIT_I) begin
                            state_q <= plc_access_pkg::ST_IDLE;
                        end else begin
                            slot_cnt_q <= slot_draw;
                            period_cnt_q <= BACKOFF_PERIOD_I;
                            state_q <= plc_access_pkg::ST_BACKOFF;
                        end
                    end
                end
                plc_access_pkg::ST_TRANSMIT: begin
                    resp_started_q <= 1'b0;
                    if (tx_end) begin
                        state_q <= ack_wanted_q ? plc_access_pkg::ST_WAIT_RESP
                            : plc_access_pkg::ST_IDLE;
                    end
                end
                plc_access_pkg::ST_WAIT_RESP: begin
                    if (RX_START_I) begin
                        resp_started_q <= 1'b1;
                    end
                    if (collision || (RX_END_I && resp_started_q)) begin
                        state_q <= plc_access_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= plc_access_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            TX_START_O <= 1'b0;
            TX_DONE_O <= 1'b0;
            COLLISION_O <= 1'b0;
            ACCESS_FAIL_O <= 1'b0;
            MEDIUM_BUSY_O <= 1'b1;
            EXTENDED_GAP_O <= 1'b0;
            BACKOFF_EXPONENT_O <= plc_access_pkg::EXP_RESET;
            BACKOFF_ATTEMPT_COUNT_O <= plc_access_pkg::COUNT_RESET;
        end else begin
            TX_START_O <= (state_q == plc_access_pkg::ST_ASSESS) && !medium_busy;
            TX_DONE_O <= (state_q == plc_access_pkg::ST_TRANSMIT && tx_end && !ack_wanted_q)
                || (state_q == plc_access_pkg::ST_WAIT_RESP && RX_END_I && resp_started_q
                && !collision);
            COLLISION_O <= collision;
            ACCESS_FAIL_O <= (state_q == plc_access_pkg::ST_ASSESS) && medium_busy
                && (attempt_next > BACKOFF_ATTEMPT_LIMIT_I);
            MEDIUM_BUSY_O <= medium_busy;
            EXTENDED_GAP_O <= (extended_gap_q != '0) || powerup_q;
            BACKOFF_EXPONENT_O <= backoff_exponent_q;
            BACKOFF_ATTEMPT_COUNT_O <= backoff_attempt_count_q;
        end
    end

endmodule : plc_mac_channel_access

// ### dv/plc_access_props.sv
// ***********************************************
// port level checks of the channel access block
// ***********************************************
module plc_access_props (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic TX_ACTIVE_I,
    input wire logic PHY_CARRIER_DETECT_I,
    input wire logic RX_END_I,
    input wire logic RX_OK_I,
    input wire logic [plc_access_pkg::EXP_W-1:0] BACKOFF_EXPONENT_CEILING_I,
    input wire logic [plc_access_pkg::CNT_W-1:0] BACKOFF_ATTEMPT_LIMIT_I,
    input wire logic TX_START_O,
    input wire logic TX_DONE_O,
    input wire logic COLLISION_O,
    input wire logic ACCESS_FAIL_O,
    input wire logic MEDIUM_BUSY_O,
    input wire logic EXTENDED_GAP_O,
    input wire logic [plc_access_pkg::EXP_W-1:0] BACKOFF_EXPONENT_O,
    input wire logic [plc_access_pkg::CNT_W-1:0] BACKOFF_ATTEMPT_COUNT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // received frame endings, garbled and clean
    sequence s_bad_end;
        RX_END_I && !RX_OK_I;
    endsequence
    sequence s_good_end;
        RX_END_I && RX_OK_I;
    endsequence
    AST_START_IDLE: assert property (TX_START_O |-> !$past(PHY_CARRIER_DETECT_I))
        else $error("start while carrier seen");
    AST_BUSY_TX: assert property (TX_ACTIVE_I |=> MEDIUM_BUSY_O)
        else $error("idle while transmitting");
    AST_BUSY_CARRIER: assert property (PHY_CARRIER_DETECT_I |=> MEDIUM_BUSY_O)
        else $error("idle with carrier");
    AST_START_PULSE: assert property (TX_START_O |=> !TX_START_O)
        else $error("start longer than a cycle");
    AST_END_EXCL: assert property (!(TX_DONE_O && COLLISION_O))
        else $error("done and collision together");
    AST_EXP_CLAMP: assert property (BACKOFF_EXPONENT_O <= BACKOFF_EXPONENT_CEILING_I)
        else $error("exponent above ceiling");
    AST_COUNT_STEP: assert property ($changed(BACKOFF_ATTEMPT_COUNT_O) |->
        BACKOFF_ATTEMPT_COUNT_O == $past(BACKOFF_ATTEMPT_COUNT_O) + 8'h01 ||
        BACKOFF_ATTEMPT_COUNT_O == 8'h00)
        else $error("attempt count jumped");
    AST_FAIL_LIMIT: assert property (ACCESS_FAIL_O |->
        ($past(BACKOFF_ATTEMPT_COUNT_O) > BACKOFF_ATTEMPT_LIMIT_I) or
        ##[0:2] (BACKOFF_ATTEMPT_COUNT_O > BACKOFF_ATTEMPT_LIMIT_I))
        else $error("failure below limit");
    AST_GAP_ARM: assert property (s_bad_end |-> ##[1:2] EXTENDED_GAP_O)
        else $error("garbled frame left gap off");
    AST_GAP_CANCEL: assert property (s_good_end |-> ##[1:2] !EXTENDED_GAP_O)
        else $error("clean frame left gap on");
endmodule : plc_access_props

bind plc_mac_channel_access plc_access_props u_props (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .TX_ACTIVE_I(TX_ACTIVE_I),
    .PHY_CARRIER_DETECT_I(PHY_CARRIER_DETECT_I),
    .RX_END_I(RX_END_I),
    .RX_OK_I(RX_OK_I),
    .BACKOFF_EXPONENT_CEILING_I(BACKOFF_EXPONENT_CEILING_I),
    .BACKOFF_ATTEMPT_LIMIT_I(BACKOFF_ATTEMPT_LIMIT_I),
    .TX_START_O(TX_START_O),
    .TX_DONE_O(TX_DONE_O),
    .COLLISION_O(COLLISION_O),
    .ACCESS_FAIL_O(ACCESS_FAIL_O),
    .MEDIUM_BUSY_O(MEDIUM_BUSY_O),
    .EXTENDED_GAP_O(EXTENDED_GAP_O),
    .BACKOFF_EXPONENT_O(BACKOFF_EXPONENT_O),
    .BACKOFF_ATTEMPT_COUNT_O(BACKOFF_ATTEMPT_COUNT_O)
);

// ### dv/phy_model.sv
// ***********************************************
// phy side: carrier and received frames
// ***********************************************
module phy_model (
    input wire logic clk_i,
    input wire logic tx_active_i,
    input wire logic send_i,
    input wire logic hold_i,
    input wire logic [2:0] kind_i,
    output logic carrier_o,
    output logic rx_start_o,
    output logic rx_is_data_o,
    output logic [15:0] rx_length_o,
    output logic rx_end_o,
    output logic rx_ok_o,
    output logic rx_is_ack_o,
    output logic rx_is_nack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act_q = 1'b0;
    logic [3:0] t_q = 4'h0;
    // frame timer: after own transmission ends, or on command
    always @(negedge clk_i) begin
        act_q <= tx_active_i;
        if (t_q == 4'h0 && kind_i != 3'h0 && (send_i || (act_q && !tx_active_i))) begin
            t_q <= 4'h1;
        end else if (t_q == 4'h8) begin
            t_q <= 4'h0;
        end else if (t_q != 4'h0) begin
            t_q <= t_q + 4'h1;
        end
    end
    // carrier spans the whole frame; kinds 1 ack 2 nack 3 data 4 garbled
    assign carrier_o = (t_q >= 4'h3) | hold_i;
    assign rx_start_o = (t_q == 4'h3);
    assign rx_end_o = (t_q == 4'h8);
    assign rx_is_data_o = rx_start_o ? (kind_i == 3'h3) : t_q[0];
    assign rx_length_o = rx_start_o ? 16'h0002 : {16{t_q[0]}};
    assign rx_ok_o = rx_end_o ? (kind_i != 3'h4) : t_q[0];
    assign rx_is_ack_o = rx_end_o ? (kind_i == 3'h1) : t_q[0];
    assign rx_is_nack_o = rx_end_o ? (kind_i == 3'h2) : t_q[0];
endmodule : phy_model

// ### dv/tb_plc_mac_channel_access.sv
module tb_plc_mac_channel_access;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXT_LEN = 2 * (2 + 4 + 2 + 2) + 4;
    localparam int WIN = 2 * 2 + 4 + plc_access_pkg::RESPONSE_SLACK_CYC;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic tx_req = 1'b0;
    logic ack_req = 1'b0;
    logic tx_active = 1'b0;
    logic send = 1'b0;
    logic hold = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [3:0] min_exp = 4'h0;
    logic [15:0] sym = 16'h0002;
    logic [15:0] bo_per = 16'h0002;
    logic [3:0] ceil_e = 4'h2;
    logic [7:0] lim = 8'h01;
    logic carrier, rx_start, rx_data, rx_end, rx_ok, rx_ack, rx_nack;
    logic [15:0] rx_len;
    logic tx_start, tx_done, coll, fail, busy, ext_gap;
    logic [3:0] exp_o;
    logic [7:0] cnt_o;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    plc_mac_channel_access u_dut (
        .CLK_I(clk),
        .NRST_I(nrst),
        .TX_REQ_I(tx_req),
        .TX_ACK_REQ_I(ack_req),
        .TX_ACTIVE_I(tx_active),
        .PHY_CARRIER_DETECT_I(carrier),
        .RX_START_I(rx_start),
        .RX_IS_DATA_I(rx_data),
        .RX_LENGTH_I(rx_len),
        .RX_END_I(rx_end),
        .RX_OK_I(rx_ok),
        .RX_IS_ACK_I(rx_ack),
        .RX_IS_NACK_I(rx_nack),
        .SYMBOL_DURATION_I(sym),
        .HEADER_SYMBOL_COUNT_I(8'h02),
        .MAX_FRAME_LENGTH_I(8'h04),
        .CONTENTION_GAP_I(8'h02),
        .RESPONSE_GAP_I(8'h02),
        .ACKNOWLEDGE_DURATION_I(16'h0004),
        .BACKOFF_PERIOD_I(bo_per),
        .MIN_BACKOFF_EXPONENT_I(min_exp),
        .BACKOFF_EXPONENT_CEILING_I(ceil_e),
        .BACKOFF_ATTEMPT_LIMIT_I(lim),
        .TX_START_O(tx_start),
        .TX_DONE_O(tx_done),
        .COLLISION_O(coll),
        .ACCESS_FAIL_O(fail),
        .MEDIUM_BUSY_O(busy),
        .EXTENDED_GAP_O(ext_gap),
        .BACKOFF_EXPONENT_O(exp_o),
        .BACKOFF_ATTEMPT_COUNT_O(cnt_o)
    );
    phy_model u_phy (
        .clk_i(clk),
        .tx_active_i(tx_active),
        .send_i(send),
        .hold_i(hold),
        .kind_i(kind),
        .carrier_o(carrier),
        .rx_start_o(rx_start),
        .rx_is_data_o(rx_data),
        .rx_length_o(rx_len),
        .rx_end_o(rx_end),
        .rx_ok_o(rx_ok),
        .rx_is_ack_o(rx_ack),
        .rx_is_nack_o(rx_nack)
    );
    // ***********************************************
    // shared tasks
    // ***********************************************
    task automatic conclude();
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    function automatic logic pick(input int s);
        case (s)
            0: return tx_start;
            1: return tx_done;
            2: return coll;
            4: return ext_gap;
            5: return !ext_gap;
            default: return !busy;
        endcase
    endfunction : pick
    task automatic wait_for(input int s, input int lim, output int n);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_for
    task automatic pulse_send();
        @(negedge clk);
        send <= 1'b1;
        @(negedge clk);
        send <= 1'b0;
    endtask : pulse_send
    // wait for idle, request, then act as transmit path for 5 cycles
    task automatic send_frame(input logic want_reply);
        int n;
        wait_for(6, 300, n);
        @(negedge clk);
        tx_req <= 1'b1;
        ack_req <= want_reply;
        @(negedge clk);
        tx_req <= 1'b0;
        wait_for(0, 100, n);
        check("tx_start", 1, 32'(n < 100));
        tx_active <= 1'b1;
        repeat (3) @(negedge clk);
        check("busy_while_tx", 1, 32'(busy));
        repeat (2) @(negedge clk);
        tx_active <= 1'b0;
    endtask : send_frame
    // ***********************************************
    // scenarios
    // ***********************************************
    task automatic t_power_up();
        int n;
        @(negedge clk);
        check("gap_at_power_up", 1, 32'(ext_gap));
        check("busy_at_power_up", 1, 32'(busy));
        wait_for(5, 100, n);
        check("gap_length", 1, 32'(n >= EXT_LEN - 3 && n <= EXT_LEN + 2));
    endtask : t_power_up
    task automatic t_no_reply();
        int n;
        kind <= 3'h0;
        send_frame(1'b0);
        wait_for(1, 4, n);
        check("done_no_reply", 1, 32'(n < 4));
        @(negedge clk);
        check("busy_in_contention_gap", 1, 32'(busy));
        wait_for(6, 20, n);
        check("contention_gap_ends", 1, 32'(n < 20));
    endtask : t_no_reply
    task automatic t_replies();
        int n;
        for (int k = 1; k < 4; k++) begin
            kind <= 3'(k);
            send_frame(1'b1);
            wait_for(k == 3 ? 2 : 1, 60, n);
            check("reply_outcome", 1, 32'(n < 60));
        end
    endtask : t_replies
    task automatic t_silent();
        int n;
        kind <= 3'h0;
        send_frame(1'b1);
        wait_for(2, 100, n);
        check("silence_window", 1, 32'(n >= WIN - 3 && n <= WIN + 3));
    endtask : t_silent
    task automatic t_busy();
        int n;
        int mx_e = 0;
        int mx_c = 0;
        logic got_fail = 1'b0;
        logic got_start = 1'b0;
        wait_for(6, 300, n);
        hold <= 1'b1;
        min_exp <= 4'h1;
        @(negedge clk);
        tx_req <= 1'b1;
        @(negedge clk);
        tx_req <= 1'b0;
        repeat (120) begin
            @(negedge clk);
            got_fail = got_fail | fail;
            got_start = got_start | tx_start;
            mx_e = (exp_o > mx_e) ? int'(exp_o) : mx_e;
            mx_c = (cnt_o > mx_c) ? int'(cnt_o) : mx_c;
        end
        check("access_fail", 1, 32'(got_fail));
        check("no_start_on_busy", 0, 32'(got_start));
        check("exponent_max", 2, mx_e);
        check("attempts_max", 2, mx_c);
        hold <= 1'b0;
        min_exp <= 4'h0;
    endtask : t_busy
    task automatic t_gap();
        int n;
        wait_for(6, 300, n);
        kind <= 3'h4;
        pulse_send();
        wait_for(4, 16, n);
        check("gap_on_garbled", 1, 32'(n < 16));
        kind <= 3'h3;
        pulse_send();
        wait_for(5, 16, n);
        check("gap_cancelled", 1, 32'(n < 16));
    endtask : t_gap
    // ***********************************************
    // main sequence and watchdog
    // ***********************************************
    initial begin
        repeat (8) @(negedge clk);
        nrst <= 1'b1;
        t_power_up();
        t_no_reply();
        t_replies();
        t_silent();
        t_busy();
        t_gap();
        conclude();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
endmodule : tb_plc_mac_channel_access
